// ---- sep_cmd_port.sv ----
// serial eeprom command port with its read prefetch fifo
// How it works
// - first one sampled on serial_in after chip select rises is the start bit
// - zeros before the start bit are ignored
// - start bit, two-bit opcode, address, data; fields msb first
// - opcode 10 reads, opcode 01 writes one sixteen-bit word
// - opcode 00: top address bits 11 enable, 01 block fill, 00 disable writes
// - address field 8 or 10 bits; top bit ignored in 128 and 512 word variants
// - read drives dummy zero on the clock taking address_lsb
// - then sixteen data_word_bits shift out msb first, one per clock rise
// - continued clocking during read increments address and streams words
// - write starts when chip select falls before clock after last data bit
// - chip select falling after a further clock rise drops the write
// - programming self-timed 10 or 5 ms; commands rejected, busy shows low
// - block fill writes one word into all 128 words of a block
// - low address bits select the block; only capacity-needed bits count
// - block fill cancelled when a further clock rise precedes chip select fall
// - after power-up writes and block fills ignored until write enable
// - write enable persists until write disable or power loss
// - reads run whether writes are enabled or not
// - chip select low cancels writes up to the final data clock
// - after the final data clock chip select low starts programming unless clocking ran on
// - serial_in sampled on each rising serial clock edge
// - status stays until next start bit; output released while chip select low
// - status turns high, ready, when programming ends; commands accepted again
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// fifo: flop storage, power-of-two depth
// ----------------------------------------------------------------
module sep_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         sys_clk_i,   // system clock
  input  wire logic         sys_rst_i,   // synchronous reset
  input  wire logic         flush_i,     // drop all entries
  input  wire logic         in_valid_i,  // write side valid
  output logic              in_ready_o,  // write side ready
  input  wire logic [W-1:0] in_data_i,   // write data
  output logic              out_valid_o, // read side valid
  input  wire logic         out_ready_i, // read side ready
  output logic [W-1:0]      out_data_o   // head entry
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sep_fifo_st_t;

  sep_fifo_st_t st_r;
  sep_fifo_st_t st_nxt;
  logic [W-1:0] buf_r [D];
  logic         push;
  logic         pop;

  // handshake flags straight from the counter
  assign in_ready_o  = (st_r.cnt != (AW+1)'(D));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = buf_r[st_r.rp];
  assign push        = in_valid_i & in_ready_o & ~flush_i;
  assign pop         = out_valid_o & out_ready_i & ~flush_i;

  // pointers wrap naturally since depth is a power of two
  always_comb begin
    st_nxt = st_r;
    if (flush_i) begin
      st_nxt = '0;
    end else begin
      if (push) st_nxt.wp = st_r.wp + AW'(1);
      if (pop) st_nxt.rp = st_r.rp + AW'(1);
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) st_r <= '0;
    else st_r <= st_nxt;
  end

  // one write port per entry
  for (genvar gi = 0; gi < D; gi++) begin : g_ent
    always_ff @(posedge sys_clk_i) begin
      if (push && st_r.wp == AW'(gi)) buf_r[gi] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------
// command port top
// ----------------------------------------------------------------
module sep_cmd_port
  import sep_pkg::*;
#(
  parameter int PROG_LONG_CYC  = `SEP_PROG_LONG_CYC,
  parameter int PROG_SHORT_CYC = `SEP_PROG_SHORT_CYC
) (
  input  wire logic       sys_clk_i,        // 125 MHz system clock
  input  wire logic       sys_rst_i,        // synchronous reset, power-up
  input  wire logic       chip_select_i,    // chip select pin, active high
  input  wire logic       serial_clock_in_i, // serial clock pin
  input  wire logic       serial_in_i,      // serial data pin
  input  wire logic [1:0] capacity_i,       // 0:128 1:256 2:512 3:1024 words
  input  wire logic       fast_prog_i,      // short programming time variant
  output logic            serial_out_o,     // serial data / ready-busy
  output logic            serial_out_oe_o,  // high while the pin is driven
  output logic            busy_o,           // programming in progress
  output logic            write_enabled_o   // write enable latch
);
  sep_state_t            st_r;
  sep_state_t            st_nxt;
  logic [15:0]           mem_r [`SEP_MEM_WORDS];
  sep_pins_t             pins;
  sep_pins_t             filt_nxt;
  logic                  sclk_rise;
  logic                  cs_hi;
  logic                  sin_bit;
  logic                  aw10;
  logic [4:0]            last_a;
  logic [4:0]            last_d;
  logic [9:0]            amask;
  logic [2:0]            bmask;
  logic [9:0]            addr_m;
  logic [2:0]            blk;
  logic                  fill;
  logic                  prog_go;
  logic                  flush;
  logic                  pop;
  logic                  f_in_rdy;
  logic                  f_out_vld;
  logic [15:0]           f_data;
  logic [4:0]            k;
  logic [9:0]            na;
  logic [1:0]            ext;

  // ----------------------------------------------------------------
  // pin conditioning: three flops, level taken once stages 2 and 3 agree
  // ----------------------------------------------------------------
  assign pins      = '{sin: serial_in_i, sclk: serial_clock_in_i, cs: chip_select_i};
  assign filt_nxt  = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
  assign sclk_rise = filt_nxt.sclk & ~st_r.filt.sclk;
  assign cs_hi     = filt_nxt.cs;
  assign sin_bit   = filt_nxt.sin;

  // capacity shapes address width and honoured block bits
  assign aw10   = capacity_i[1];
  assign last_a = aw10 ? 5'd13 : 5'd11;
  assign last_d = last_a + 5'(`SEP_WORD_W);
  assign amask  = 10'h3ff >> (2'd3 - capacity_i);
  assign bmask  = 3'b111 >> (2'd3 - capacity_i);
  assign addr_m = st_r.addr & amask;
  assign blk    = st_r.addr[2:0] & bmask;
  assign fill   = (st_r.op == `SEP_OP_EXT);

  // ----------------------------------------------------------------
  // read prefetch fifo: keeps words ready so a fast serial clock never starves
  // ----------------------------------------------------------------
  sep_fifo #(
    .W (`SEP_WORD_W),
    .D (`SEP_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (flush),
    .in_valid_i  (st_r.pf_on),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (mem_r[st_r.pf_addr]),
    .out_valid_o (f_out_vld),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    pop      = 1'b0;
    flush    = 1'b0;
    prog_go  = 1'b0;
    ext      = 2'b00;
    k        = st_r.cnt + 5'd1;
    na       = {st_r.addr[8:0], sin_bit};
    st_nxt.s1   = pins;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = filt_nxt;
    // prefetcher walks on while the fifo has room; wraps inside capacity
    if (st_r.pf_on && f_in_rdy) st_nxt.pf_addr = (st_r.pf_addr + 10'd1) & amask;
    case (st_r.fsm)
      ST_IDLE: begin
        // zeros before the start bit simply leave us here
        if (cs_hi && sclk_rise && sin_bit) begin
          st_nxt.fsm       = ST_CMD;
          st_nxt.cnt       = `SEP_CLK_START;
          st_nxt.op        = 2'b00;
          st_nxt.addr      = '0;
          st_nxt.data      = '0;
          st_nxt.status_en = 1'b0;
        end
      end
      ST_CMD: begin
        if (!cs_hi) begin
          st_nxt.fsm = ST_IDLE;
        end else if (sclk_rise) begin
          st_nxt.cnt = k;
          if (k <= `SEP_OP_LAST) st_nxt.op = {st_r.op[0], sin_bit};
          else if (k <= last_a) st_nxt.addr = na;
          else st_nxt.data = {st_r.data[14:0], sin_bit};
          if (k == last_a) begin
            case (st_r.op)
              `SEP_OP_READ: begin
                st_nxt.fsm     = ST_READ;
                st_nxt.dout    = 1'b0;
                st_nxt.bitcnt  = 4'd0;
                st_nxt.pf_addr = na & amask;
                st_nxt.pf_on   = 1'b1;
                flush          = 1'b1;
              end
              `SEP_OP_EXT: begin
                ext = aw10 ? na[9:8] : na[7:6];
                case (ext)
                  `SEP_EXT_WEN: begin
                    st_nxt.wen = 1'b1;
                    st_nxt.fsm = ST_DONE;
                  end
                  `SEP_EXT_WDIS: begin
                    st_nxt.wen = 1'b0;
                    st_nxt.fsm = ST_DONE;
                  end
                  `SEP_EXT_FILL: st_nxt.fsm = ST_CMD;
                  default: st_nxt.fsm = ST_DONE;
                endcase
              end
              `SEP_OP_WRITE: st_nxt.fsm = ST_CMD;
              default: st_nxt.fsm = ST_DONE;
            endcase
          end
          // the final data edge itself cannot cancel
          if (k == last_d) st_nxt.fsm = ST_WAIT;
        end
      end
      ST_READ: begin
        if (!cs_hi) begin
          st_nxt.fsm   = ST_IDLE;
          st_nxt.pf_on = 1'b0;
        end else if (sclk_rise) begin
          // a word leaves the fifo on its first bit; the shifter serves the other fifteen
          if (st_r.bitcnt == 4'd0) begin
            pop           = f_out_vld;
            st_nxt.dout   = f_data[15];
            st_nxt.sh     = {f_data[14:0], 1'b0};
            st_nxt.bitcnt = 4'd15;
          end else begin
            st_nxt.dout   = st_r.sh[15];
            st_nxt.sh     = {st_r.sh[14:0], 1'b0};
            st_nxt.bitcnt = st_r.bitcnt - 4'd1;
          end
        end
      end
      ST_WAIT: begin
        // chip select low wins over a clock edge seen in the same cycle
        if (!cs_hi) begin
          if (st_r.wen) begin
            prog_go          = 1'b1;
            // write and fill share one timer, so both report the same busy time
            st_nxt.fsm       = ST_PROG;
            st_nxt.timer     = fast_prog_i ? `SEP_TIMER_W'(PROG_SHORT_CYC)
                                           : `SEP_TIMER_W'(PROG_LONG_CYC);
            st_nxt.status_en = 1'b1;
          end else begin
            st_nxt.fsm = ST_IDLE;
          end
        end else if (sclk_rise) begin
          st_nxt.fsm = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!cs_hi) st_nxt.fsm = ST_IDLE;
      end
      ST_PROG: begin
        // every command on the pins is ignored until the timer runs out; chip select only gates the status output
        if (st_r.timer == `SEP_TIMER_W'(1)) st_nxt.fsm = ST_IDLE;
        else st_nxt.timer = st_r.timer - `SEP_TIMER_W'(1);
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase
    // status: low while busy, high once ready; pin released with chip select low
    if (st_nxt.status_en) st_nxt.dout = (st_nxt.fsm != ST_PROG);
    st_nxt.oe = cs_hi & ((st_nxt.fsm == ST_READ) | st_nxt.status_en);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r     <= '0;
      st_r.fsm <= ST_IDLE;
      st_r.wen <= `SEP_WEN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // cell array: the whole write lands at programming start, timer models the busy time
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < `SEP_MEM_WORDS; gi++) begin : g_cell
    localparam logic [9:0] IDX = 10'(gi);
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) mem_r[gi] <= `SEP_ERASED_WORD;
      else if (prog_go && (fill ? (IDX[9:`SEP_BLK_LSB] == blk) : (IDX == addr_m)))
        mem_r[gi] <= st_r.data;
    end
  end

  assign serial_out_o    = st_r.dout;
  assign serial_out_oe_o = st_r.oe;
  assign busy_o          = (st_r.fsm == ST_PROG);
  assign write_enabled_o = st_r.wen;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_start_bit_seen: assert property ((st_r.fsm == ST_IDLE) && cs_hi && sclk_rise && sin_bit
    |=> (st_r.fsm == ST_CMD) && (st_r.cnt == 5'd1)) else $error("start bit missed");
  a_zero_pad_ignored: assert property ((st_r.fsm == ST_IDLE) && sclk_rise && !sin_bit
    |=> st_r.fsm == ST_IDLE) else $error("leading zero began a command");
  a_dummy_zero_out: assert property ((st_r.fsm == ST_CMD) && cs_hi && sclk_rise
    && (k == last_a) && (st_r.op == `SEP_OP_READ)
    |=> (st_r.fsm == ST_READ) && !serial_out_o && serial_out_oe_o)
    else $error("no dummy zero on read");
  a_read_shift_bit: assert property ((st_r.fsm == ST_READ) && cs_hi && sclk_rise
    && (st_r.bitcnt != 4'd0) |=> serial_out_o == $past(st_r.sh[15]))
    else $error("read bit out of order");
  a_late_clock_cancel: assert property ((st_r.fsm == ST_WAIT) && cs_hi && sclk_rise
    |=> (st_r.fsm == ST_DONE) ##1 !busy_o) else $error("late write not cancelled");
  a_write_gated_wen: assert property ((st_r.fsm == ST_WAIT) && !cs_hi && !st_r.wen
    |=> (st_r.fsm == ST_IDLE) && !busy_o) else $error("write ran while disabled");
  a_busy_shows_low: assert property (busy_o && serial_out_oe_o |-> !serial_out_o)
    else $error("busy not shown low");
  a_release_cs_low: assert property (!cs_hi |=> !serial_out_oe_o)
    else $error("output driven with chip select low");
  a_prog_start_busy: assert property ((st_r.fsm == ST_WAIT) && !cs_hi && st_r.wen
    |=> busy_o && st_r.status_en) else $error("programming did not start");
  a_ready_after_prog: assert property (busy_o && (st_r.timer == `SEP_TIMER_W'(1))
    |=> !busy_o && st_r.dout) else $error("ready not shown after programming");
  a_wen_holds: assert property ((st_r.fsm != ST_CMD) && write_enabled_o
    |=> write_enabled_o) else $error("write enable dropped");

  // cancellation, status release, timer length and the enable latch
  a_cancel_before_end: assert property ((st_r.fsm == ST_CMD) && !cs_hi
    |=> (st_r.fsm == ST_IDLE) && !busy_o) else $error("cut command not dropped");
  a_start_clears_status: assert property ((st_r.fsm == ST_IDLE) && cs_hi && sclk_rise
    && sin_bit |=> !serial_out_oe_o) else $error("status kept after start bit");
  a_busy_ignores_pins: assert property (busy_o && (st_r.timer != `SEP_TIMER_W'(1))
    |=> busy_o) else $error("programming cut short");
  a_enable_cmd_sets: assert property ((st_r.fsm == ST_CMD) && cs_hi && sclk_rise
    && (k == last_a) && (st_r.op == `SEP_OP_EXT) && (ext == `SEP_EXT_WEN)
    |=> write_enabled_o) else $error("enable command lost");
endmodule

`default_nettype wire

// ---- sep_host_model.sv ----
// host model that drives the serial command pins of the eeprom port
`timescale 1ns/1ns
`default_nettype none
module sep_host_model (
  output logic      chip_select_o,  // chip select to the device
  output logic      serial_clock_o, // serial clock, still outside frames
  output logic      serial_data_o,  // serial data to the device
  input  wire logic serial_out_i    // serial output of the device
);
  initial begin
    chip_select_o  = 1'b0;
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame control
  // ----------------------------------------------------------------
  // data held low while selecting, so a status phase never sees a start bit
  task automatic select(input logic on);
    serial_data_o = 1'b0;
    chip_select_o = on;
    #125;
  endtask

  // n bits msb first at a 125 ns period; data changes at the falling edge,
  // output is sampled just before each rise, when the last rise's bit has settled
  task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_o = bits[i];
      #63;
      got = {got[30:0], serial_out_i};
      serial_clock_o = 1'b1;
      #62;
      serial_clock_o = 1'b0;
    end
    #63;
    got = {got[30:0], serial_out_i};
  endtask
endmodule
`default_nettype wire

// ---- sep_pkg.sv ----
// types shared by the serial eeprom command port
`include "sep_regs.svh"
package sep_pkg;

  // ----------------------------------------------------------------
  // command sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD  = 6'b000010,
    ST_READ = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_DONE = 6'b010000,
    ST_PROG = 6'b100000
  } sep_fsm_t;

  // the three serial pins travel together
  typedef struct packed {
    logic sin;
    logic sclk;
    logic cs;
  } sep_pins_t;

  // whole state of the command port except the cell array and fifo
  typedef struct packed {
    sep_fsm_t                 fsm;
    sep_pins_t                s1;
    sep_pins_t                s2;
    sep_pins_t                s3;
    sep_pins_t                filt;
    logic [4:0]               cnt;
    logic [1:0]               op;
    logic [`SEP_ADDR_W-1:0]   addr;
    logic [`SEP_WORD_W-1:0]   data;
    logic [`SEP_WORD_W-1:0]   sh;
    logic [3:0]               bitcnt;
    logic [`SEP_ADDR_W-1:0]   pf_addr;
    logic                     pf_on;
    logic [`SEP_TIMER_W-1:0]  timer;
    logic                     wen;
    logic                     status_en;
    logic                     dout;
    logic                     oe;
  } sep_state_t;

endpackage

// ---- sep_regs.svh ----
// constants of the serial eeprom command port: opcodes, field positions and timing
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// ----------------------------------------------------------------
// command encodings
// ----------------------------------------------------------------
`define SEP_OP_EXT        2'b00
`define SEP_OP_WRITE      2'b01
`define SEP_OP_READ       2'b10
`define SEP_EXT_WDIS      2'b00
`define SEP_EXT_FILL      2'b01
`define SEP_EXT_WEN       2'b11

// ----------------------------------------------------------------
// field positions and sizes
// ----------------------------------------------------------------
`define SEP_PIN_CS        0
`define SEP_PIN_SCLK      1
`define SEP_PIN_SIN       2
`define SEP_CLK_START     5'd1
`define SEP_OP_LAST       5'd3
`define SEP_WORD_W        16
`define SEP_ADDR_W        10
`define SEP_MEM_WORDS     1024
`define SEP_BLK_LSB       7
`define SEP_FIFO_DEPTH    8
`define SEP_ERASED_WORD   16'hffff
`define SEP_WEN_RESET     1'b0

// ----------------------------------------------------------------
// timing (longest times round down)
// ----------------------------------------------------------------
`define SEP_CLK_NS        8
`define SEP_PROG_LONG_MS   10
`define SEP_PROG_SHORT_MS  5
`define SEP_PROG_LONG_CYC  ((`SEP_PROG_LONG_MS * 1000000) / `SEP_CLK_NS)
`define SEP_PROG_SHORT_CYC ((`SEP_PROG_SHORT_MS * 1000000) / `SEP_CLK_NS)
`define SEP_TIMER_W       21

`endif

// ---- test_serial_eeprom_command_port.sv ----
// self-checking bench of the serial eeprom command port
`timescale 1ns/1ns
`default_nettype none
`include "sep_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_serial_eeprom_command_port
  import sep_pkg::*;
;
  localparam int PL = 600;
  localparam int PS = 300;
  logic        sys_clk_i, sys_rst_i, cs, sclk, sdat, dout, dout_oe, busy, wen, fast, so_line;
  logic [1:0]  cap;
  logic [15:0] mem [1024];
  logic [31:0] got;
  logic [9:0]  a, b, base;
  logic [15:0] d;
  int          errors, compares, blen, last_len;

  sep_cmd_port #(.PROG_LONG_CYC(PL), .PROG_SHORT_CYC(PS)) sep_cmd_port_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .chip_select_i(cs),
    .serial_clock_in_i(sclk), .serial_in_i(sdat), .capacity_i(cap), .fast_prog_i(fast),
    .serial_out_o(dout), .serial_out_oe_o(dout_oe), .busy_o(busy),
    .write_enabled_o(wen));
  // a released output line rests at its pull-up level, not at the last driven bit
  assign so_line = dout_oe ? dout : 1'b1;
  sep_host_model sep_host_model_i (
    .chip_select_o(cs), .serial_clock_o(sclk), .serial_data_o(sdat), .serial_out_i(so_line));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // length of the last busy period, to check the programming time
  always @(posedge sys_clk_i) begin
    if (busy === 1'b1) blen <= blen + 1;
    else if (blen != 0) begin
      last_len <= blen;
      blen     <= 0;
    end
  end

  // ----------------------------------------------------------------
  // expectations and bus helpers
  // ----------------------------------------------------------------
  function automatic int alen();
    return (cap >= 2'd2) ? 10 : 8;
  endfunction
  function automatic int words();
    return 128 << cap;
  endfunction
  function automatic logic [31:0] cmdv(input logic [1:0] op, input logic [9:0] ad);
    return (32'h1 << (alen() + 2)) | (32'(op) << alen()) | (32'(ad) & ((32'h1 << alen()) - 1));
  endfunction
  // extended command: selector in the top two address bits, rest don't-care except a fill's block bits
  function automatic logic [9:0] xaddr(input logic [1:0] ext, input logic [9:0] low);
    return 10'((32'(ext) << (alen() - 2)) | (32'(low) & ((32'h1 << (alen() - 2)) - 1)));
  endfunction

  task automatic send(input logic [1:0] op, input logic [9:0] ad, input logic [15:0] dat,
                      input int nd, input int extra, input int pad);
    sep_host_model_i.select(1'b1);
    if (pad > 0) sep_host_model_i.shift(32'h0, pad, got);
    sep_host_model_i.shift(cmdv(op, ad), alen() + 3, got);
    if (nd > 0) sep_host_model_i.shift(32'(dat) >> (16 - nd), nd, got);
    if (extra > 0) sep_host_model_i.shift(32'h0, extra, got);
    sep_host_model_i.select(1'b0);
  endtask

  task automatic read_chk(input logic [9:0] ad, input int n);
    int x;
    sep_host_model_i.select(1'b1);
    sep_host_model_i.shift(cmdv(`SEP_OP_READ, ad), alen() + 3, got);
    `CHK(got[0], 1'b0)
    x = int'(ad) % words();
    for (int w = 0; w < n; w++) begin
      sep_host_model_i.shift(32'h0, 16, got);
      `CHK(got[15:0], mem[x])
      x = (x + 1) % words();
    end
    `CHK(dout_oe, 1'b1)
    sep_host_model_i.select(1'b0);
    `CHK(dout_oe, 1'b0)
  endtask

  // status phase: busy low until the timer ends, then ready high
  task automatic prog_wait(input int exp);
    int c;
    sep_host_model_i.select(1'b1);
    `CHK({dout_oe, dout}, 2'b10)
    c = 0;
    while (busy !== 1'b0 && c < 4 * PL) begin
      @(posedge sys_clk_i);
      c++;
    end
    repeat (6) @(posedge sys_clk_i);
    `CHK({dout_oe, dout}, 2'b11)
    `CHK(last_len >= exp - 3 && last_len <= exp + 3, 1'b1)
    sep_host_model_i.select(1'b0);
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // the whole run is near 20k cycles; the limit leaves wide margin
  initial begin
    #600000;
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha7c0));
    sys_rst_i = 1'b1;
    cap = 2'd3;
    fast = 1'b0;
    blen = 0;
    last_len = 0;
    for (int i = 0; i < 1024; i++) mem[i] = `SEP_ERASED_WORD;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    `CHK({wen, busy, dout_oe}, 3'b000)
    // a write before enabling must be dropped
    a = 10'($urandom);
    send(`SEP_OP_WRITE, a, 16'h1234, 16, 0, 0);
    `CHK(busy, 1'b0)
    read_chk(a, 1);
    // enable, padded with leading zeros
    send(`SEP_OP_EXT, xaddr(`SEP_EXT_WEN, 10'($urandom)), 16'h0, 0, 0, 3);
    `CHK(wen, 1'b1)
    // first write; a disable sent while busy must be ignored
    d = 16'($urandom);
    send(`SEP_OP_WRITE, a, d, 16, 0, 0);
    mem[a] = d;
    `CHK(busy, 1'b1)
    send(`SEP_OP_EXT, xaddr(`SEP_EXT_WDIS, 10'h0), 16'h0, 0, 0, 0);
    `CHK(wen, 1'b1)
    prog_wait(PL);
    read_chk(a, 3);
    // random writes with random programming time
    for (int i = 0; i < 3; i++) begin
      a = 10'($urandom);
      d = 16'($urandom);
      fast <= (i == 0) ? 1'b1 : 1'($urandom);
      @(posedge sys_clk_i);
      send(`SEP_OP_WRITE, a, d, 16, 0, 0);
      mem[a] = d;
      `CHK(busy, 1'b1)
      prog_wait(fast ? PS : PL);
      read_chk(a, 2);
    end
    // cancelled writes: chip select low mid data, or after a further clock
    send(`SEP_OP_WRITE, a, ~d, 8, 0, 0);
    `CHK(busy, 1'b0)
    send(`SEP_OP_WRITE, a, ~d, 16, 1, 0);
    `CHK(busy, 1'b0)
    // unused opcode and unused extended code must not program
    send(2'b11, a, ~d, 16, 0, 0);
    `CHK(busy, 1'b0)
    send(`SEP_OP_EXT, xaddr(2'b10, 10'($urandom)), ~d, 16, 0, 0);
    `CHK(busy, 1'b0)
    read_chk(a, 1);
    // block fill for every capacity, checked at both block ends
    for (int c = 0; c < 4; c++) begin
      cap <= 2'(c);
      fast <= 1'($urandom);
      @(posedge sys_clk_i);
      b = 10'($urandom);
      d = 16'($urandom);
      base = 10'(32'(b[2:0] & 3'((1 << c) - 1)) * 128);
      send(`SEP_OP_EXT, xaddr(`SEP_EXT_FILL, b), d, 16, 0, 0);
      for (int k = 0; k < 128; k++) mem[int'(base) + k] = d;
      `CHK(busy, 1'b1)
      prog_wait(fast ? PS : PL);
      read_chk(base, 1);
      read_chk(base + 10'd127 + ((c == 0) ? 10'h80 : 10'h0), 2);
    end
    send(`SEP_OP_EXT, xaddr(`SEP_EXT_FILL, b), ~d, 16, 1, 0);
    `CHK(busy, 1'b0)
    read_chk(base, 1);
    // disable, after which writes are dropped again
    send(`SEP_OP_EXT, xaddr(`SEP_EXT_WDIS, 10'($urandom)), 16'h0, 0, 0, 0);
    `CHK(wen, 1'b0)
    send(`SEP_OP_WRITE, a, ~d, 16, 0, 0);
    `CHK(busy, 1'b0)
    read_chk(a, 1);
    // a second reset in mid-run acts as power-up: latch clear, array erased
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    `CHK({wen, busy, dout_oe}, 3'b000)
    for (int i = 0; i < 1024; i++) mem[i] = `SEP_ERASED_WORD;
    read_chk(a, 2);
    report_and_stop();
  end
endmodule
`default_nettype wire
